// File: core/rxsec_lookup.sv
// How it works
// RULE1: Long source mode takes the 8-octet source address as peer pattern, length eight.
// RULE2: Short source mode ends the peer pattern with the 2-octet source address, length four.
// RULE3: Short source mode starts the peer pattern with the source network id, or destination id when compression is set.
// RULE4: A found key starts the revocation walk with the peer pattern and length, whose failure fails the search.
// RULE5: On success a pass is reported with the chosen key, link and peer indices together.
// RULE6: The key search visits every key and every match entry, comparing length and pattern.
// RULE7: The first entry matching in length and pattern ends the key scan and starts the walk, none matching gives fail.
// RULE8: Match length code zero means five octets, one means nine, others never match.
// RULE9: The walk steps through the key's links and fetches the peer named by each link.
// RULE10: A single-peer link returns at once, pass when not revoked and fail when revoked.
// RULE11: A shared link is compared with the peer; a match returns by the revoked flag, else the walk goes on.
// RULE12: Running out of links without a return gives fail.
// RULE13: Length four compares the pattern with network id joined to short id.
// RULE14: Length eight compares the pattern with the long id; any other length fails.
`timescale 1ns/10ps
`default_nettype none
module rxsec_lookup #(
	parameter int N_KEYS = 4,
	parameter int N_MATCH = 2,
	parameter int N_LINKS = 4,
	parameter int N_PEERS = 8,
	localparam int KW = $clog2(N_KEYS),
	localparam int MW = $clog2(N_MATCH),
	localparam int LW = $clog2(N_LINKS),
	localparam int PW = $clog2(N_PEERS)
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// Register port
	input wire logic [3:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// Frame fields
	input wire logic start_i,
	input wire logic [1:0] src_mode_i,
	input wire logic net_comp_i,
	input wire logic [15:0] src_net_id_i,
	input wire logic [15:0] dst_net_id_i,
	input wire logic [63:0] src_addr_i,
	input wire logic [71:0] key_pattern_i,
	input wire logic [3:0] key_len_i,
	// Key match table
	output logic [KW-1:0] km_key_o,
	output logic [MW-1:0] km_idx_o,
	input wire logic km_valid_i,
	input wire logic [1:0] km_code_i,
	input wire logic [71:0] km_pattern_i,
	// Key peer link table
	output logic [LW-1:0] lk_idx_o,
	input wire logic lk_valid_i,
	input wire logic [PW-1:0] lk_peer_idx_i,
	input wire logic lk_single_i,
	input wire logic lk_revoked_i,
	// Peer table
	output logic [PW-1:0] pe_idx_o,
	input wire logic [15:0] pe_net_id_i,
	input wire logic [15:0] pe_short_id_i,
	input wire logic [63:0] pe_long_id_i,
	// Result
	output logic busy_o,
	output logic done_o,
	output logic pass_o
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [3:0] code_len(input logic [1:0] code);
		// RULE8: length code decode
		unique case (code)
			rxsec_pkg::CODE_FIVE: code_len = rxsec_pkg::KLEN_FIVE;
			rxsec_pkg::CODE_NINE: code_len = rxsec_pkg::KLEN_NINE;
			default: code_len = rxsec_pkg::PLEN_NONE;
		endcase
	endfunction

	function automatic logic key_hit(input logic [1:0] code,
		input logic [71:0] pat, input logic [3:0] klen,
		input logic [71:0] kpat);
		logic [3:0] len;
		len = code_len(code);
		key_hit = 1'b0;
		if (len == rxsec_pkg::KLEN_FIVE && klen == len)
		begin
			key_hit = (pat[39:0] == kpat[39:0]);
		end
		else if (len == rxsec_pkg::KLEN_NINE && klen == len)
		begin
			key_hit = (pat == kpat);
		end
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	rxsec_pkg::rxsec_state_t st_q, st_d;
	logic [KW-1:0] kidx_q, kidx_d;
	logic [MW-1:0] midx_q, midx_d;
	logic [LW-1:0] lidx_q, lidx_d;
	logic [PW-1:0] pidx_q, pidx_d;
	logic [63:0] ppat_q, ppat_d;
	logic [3:0] plen_q, plen_d;
	logic [71:0] kpat_q, kpat_d;
	logic [3:0] klen_q, klen_d;
	logic single_q, single_d;
	logic rev_q, rev_d;
	logic busy_q, busy_d;
	logic done_q, done_d;
	logic pass_q, pass_d;
	logic sdone_q, sdone_d;
	logic [31:0] rdata_q, rdata_d;
	logic start;
	logic khit;

	rxsec_cmp_if cmp_if ();

	assign cmp_if.pattern = ppat_q;
	assign cmp_if.len = plen_q;
	assign cmp_if.net_id = pe_net_id_i;
	assign cmp_if.short_id = pe_short_id_i;
	assign cmp_if.long_id = pe_long_id_i;

	rxsec_peer_cmp u_cmp (
		.c(cmp_if.cmp)
	);

	assign start = start_i | (wr_i && addr_i == rxsec_pkg::REG_CTRL &&
		wdata_i[rxsec_pkg::CTRL_START_BIT]);
	assign khit = km_valid_i && key_hit(km_code_i, km_pattern_i,
		klen_q, kpat_q);

	// ----------------------------------------
	// Sequencer and registers
	// ----------------------------------------
	always_comb
	begin
		st_d = st_q;
		kidx_d = kidx_q;
		midx_d = midx_q;
		lidx_d = lidx_q;
		pidx_d = pidx_q;
		ppat_d = ppat_q;
		plen_d = plen_q;
		kpat_d = kpat_q;
		klen_d = klen_q;
		single_d = single_q;
		rev_d = rev_q;
		busy_d = busy_q;
		done_d = 1'b0;
		pass_d = pass_q;
		sdone_d = sdone_q;
		unique case (st_q)
			rxsec_pkg::ST_IDLE:
			begin
				if (start)
				begin
					kpat_d = key_pattern_i;
					klen_d = key_len_i;
					kidx_d = '0;
					midx_d = '0;
					busy_d = 1'b1;
					pass_d = 1'b0;
					sdone_d = 1'b0;
					st_d = rxsec_pkg::ST_KRD;
					ppat_d = '0;
					plen_d = rxsec_pkg::PLEN_NONE;
					// RULE1: long source pattern
					if (src_mode_i == rxsec_pkg::MODE_LONG)
					begin
						ppat_d = src_addr_i;
						plen_d = rxsec_pkg::PLEN_LONG;
					end
					else if (src_mode_i == rxsec_pkg::MODE_SHORT)
					begin
						// RULE3: network id choice
						ppat_d[31:16] = net_comp_i ? dst_net_id_i :
							src_net_id_i;
						// RULE2: short source tail
						ppat_d[15:0] = src_addr_i[15:0];
						plen_d = rxsec_pkg::PLEN_SHORT;
					end
				end
			end
			rxsec_pkg::ST_KRD: st_d = rxsec_pkg::ST_KCHK;
			rxsec_pkg::ST_KCHK:
			begin
				// RULE7: stop on key match
				if (khit)
				begin
					// RULE4: start revocation walk
					lidx_d = '0;
					st_d = rxsec_pkg::ST_LRD;
				end
				// RULE6: scan all match entries
				else if (midx_q != MW'(N_MATCH - 1))
				begin
					midx_d = midx_q + 1'b1;
					st_d = rxsec_pkg::ST_KRD;
				end
				else if (kidx_q != KW'(N_KEYS - 1))
				begin
					kidx_d = kidx_q + 1'b1;
					midx_d = '0;
					st_d = rxsec_pkg::ST_KRD;
				end
				else
				begin
					done_d = 1'b1;
					st_d = rxsec_pkg::ST_IDLE;
				end
			end
			rxsec_pkg::ST_LRD: st_d = rxsec_pkg::ST_LCHK;
			rxsec_pkg::ST_LCHK:
			begin
				// RULE12: end of link list
				if (!lk_valid_i)
				begin
					done_d = 1'b1;
					st_d = rxsec_pkg::ST_IDLE;
				end
				else
				begin
					// RULE9: fetch linked peer
					pidx_d = lk_peer_idx_i;
					single_d = lk_single_i;
					rev_d = lk_revoked_i;
					st_d = rxsec_pkg::ST_PRD;
				end
			end
			rxsec_pkg::ST_PRD: st_d = rxsec_pkg::ST_PCHK;
			rxsec_pkg::ST_PCHK:
			begin
				// RULE10: single peer returns at once
				// RULE11: shared peer must compare
				if (single_q || cmp_if.hit)
				begin
					done_d = 1'b1;
					pass_d = !rev_q;
					st_d = rxsec_pkg::ST_IDLE;
				end
				else if (lidx_q != LW'(N_LINKS - 1))
				begin
					lidx_d = lidx_q + 1'b1;
					st_d = rxsec_pkg::ST_LRD;
				end
				else
				begin
					done_d = 1'b1;
					st_d = rxsec_pkg::ST_IDLE;
				end
			end
		endcase
		if (done_d)
		begin
			busy_d = 1'b0;
			sdone_d = 1'b1;
		end
		rdata_d = rxsec_pkg::RDATA_RESET;
		if (rd_i)
		begin
			if (addr_i == rxsec_pkg::REG_STATUS)
			begin
				rdata_d[rxsec_pkg::STAT_BUSY_BIT] = busy_q;
				rdata_d[rxsec_pkg::STAT_DONE_BIT] = sdone_q;
				rdata_d[rxsec_pkg::STAT_PASS_BIT] = pass_q;
			end
			else if (addr_i == rxsec_pkg::REG_RESULT)
			begin
				// RULE5: selected entries
				rdata_d[rxsec_pkg::RES_KEY_POS +: KW] = kidx_q;
				rdata_d[rxsec_pkg::RES_LINK_POS +: LW] = lidx_q;
				rdata_d[rxsec_pkg::RES_PEER_POS +: PW] = pidx_q;
			end
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			st_q <= rxsec_pkg::ST_IDLE;
			kidx_q <= '0;
			midx_q <= '0;
			lidx_q <= '0;
			pidx_q <= '0;
			ppat_q <= '0;
			plen_q <= rxsec_pkg::PLEN_NONE;
			kpat_q <= '0;
			klen_q <= rxsec_pkg::PLEN_NONE;
			single_q <= 1'b0;
			rev_q <= 1'b0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			pass_q <= 1'b0;
			sdone_q <= 1'b0;
			rdata_q <= rxsec_pkg::RDATA_RESET;
		end
		else
		begin
			st_q <= st_d;
			kidx_q <= kidx_d;
			midx_q <= midx_d;
			lidx_q <= lidx_d;
			pidx_q <= pidx_d;
			ppat_q <= ppat_d;
			plen_q <= plen_d;
			kpat_q <= kpat_d;
			klen_q <= klen_d;
			single_q <= single_d;
			rev_q <= rev_d;
			busy_q <= busy_d;
			done_q <= done_d;
			pass_q <= pass_d;
			sdone_q <= sdone_d;
			rdata_q <= rdata_d;
		end
	end

	assign rdata_o = rdata_q;
	assign km_key_o = kidx_q;
	assign km_idx_o = midx_q;
	assign lk_idx_o = lidx_q;
	assign pe_idx_o = pidx_q;
	assign busy_o = busy_q;
	assign done_o = done_q;
	assign pass_o = pass_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);

	wire idle_go = (st_q == rxsec_pkg::ST_IDLE) && start;
	wire kchk = (st_q == rxsec_pkg::ST_KCHK);
	wire pchk = (st_q == rxsec_pkg::ST_PCHK);

	a_long_pattern: assert property (idle_go && src_mode_i == 2'h3 |=> // RULE1
		plen_q == 4'h8 && ppat_q == $past(src_addr_i))
		else $error("long peer pattern wrong");
	a_short_tail: assert property (idle_go && src_mode_i == 2'h2 |=> // RULE2
		plen_q == 4'h4 && ppat_q[15:0] == $past(src_addr_i[15:0]))
		else $error("short peer pattern wrong");
	a_net_choice: assert property (idle_go && src_mode_i == 2'h2 && // RULE3
		net_comp_i |=> ppat_q[31:16] == $past(dst_net_id_i))
		else $error("network id choice wrong");
	a_key_walk: assert property (kchk && khit |=> // RULE4
		st_q == rxsec_pkg::ST_LRD ##2 st_q == rxsec_pkg::ST_PRD ||
		done_q) else $error("walk not started after key hit");
	a_pass_result: assert property (pchk && single_q && !rev_q |=> // RULE5
		done_q && pass_q && kidx_q == $past(kidx_q) &&
		pidx_q == $past(pidx_q)) else $error("pass result wrong");
	a_scan_next: assert property (kchk && !khit && // RULE6
		midx_q != MW'(N_MATCH - 1) |=> st_q == rxsec_pkg::ST_KRD &&
		midx_q == $past(midx_q) + 1'b1) else $error("scan skipped entry");
	a_key_miss: assert property (kchk && !khit && // RULE7
		midx_q == MW'(N_MATCH - 1) && kidx_q == KW'(N_KEYS - 1) |=>
		done_q && !pass_q) else $error("miss not failed");
	a_code_decode: assert property (kchk && km_code_i > 2'h1 |-> // RULE8
		!khit) else $error("illegal code matched");
	a_peer_fetch: assert property ((st_q == rxsec_pkg::ST_LCHK) && // RULE9
		lk_valid_i |=> pe_idx_o == $past(lk_peer_idx_i))
		else $error("peer index not taken");
	a_single_rev: assert property (pchk && single_q && rev_q |=> // RULE10
		done_q && !pass_q) else $error("revoked single passed");
	a_shared_go: assert property (pchk && !single_q && !cmp_if.hit && // RULE11
		lidx_q != LW'(N_LINKS - 1) |=> st_q == rxsec_pkg::ST_LRD &&
		!done_q) else $error("shared miss did not continue");
	a_links_end: assert property ((st_q == rxsec_pkg::ST_LCHK) && // RULE12
		!lk_valid_i |=> done_q && !pass_q) else $error("list end not fail");

	c_pass: cover property (done_q && pass_q);
	c_key_miss: cover property (kchk && !khit ##1 done_q);
	c_revoked: cover property (pchk && rev_q ##1 done_q && !pass_q);
	c_shared_hit: cover property (pchk && !single_q && cmp_if.hit);
endmodule
`default_nettype wire

// File: shared/rxsec_pkg.sv
`default_nettype none
package rxsec_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_RESULT = 4'h8;
	localparam int CTRL_START_BIT = 0;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_PASS_BIT = 2;
	localparam int RES_KEY_POS = 0;
	localparam int RES_LINK_POS = 8;
	localparam int RES_PEER_POS = 16;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

	// ----------------------------------------
	// Address modes and lengths
	// ----------------------------------------
	localparam logic [1:0] MODE_SHORT = 2'h2;
	localparam logic [1:0] MODE_LONG = 2'h3;
	localparam logic [3:0] PLEN_NONE = 4'h0;
	localparam logic [3:0] PLEN_SHORT = 4'h4;
	localparam logic [3:0] PLEN_LONG = 4'h8;
	localparam logic [3:0] KLEN_FIVE = 4'h5;
	localparam logic [3:0] KLEN_NINE = 4'h9;
	localparam logic [1:0] CODE_FIVE = 2'h0;
	localparam logic [1:0] CODE_NINE = 2'h1;

	// ----------------------------------------
	// Search sequencer states
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_KRD,
		ST_KCHK,
		ST_LRD,
		ST_LCHK,
		ST_PRD,
		ST_PCHK
	} rxsec_state_t;
endpackage
`default_nettype wire

// File: shared/rxsec_cmp_if.sv
`timescale 1ns/10ps
`default_nettype none
interface rxsec_cmp_if;
	logic [63:0] pattern;
	logic [3:0] len;
	logic [15:0] net_id;
	logic [15:0] short_id;
	logic [63:0] long_id;
	logic hit;
	modport req (output pattern, len, net_id, short_id, long_id, input hit);
	modport cmp (input pattern, len, net_id, short_id, long_id, output hit);
endinterface
`default_nettype wire

// File: core/rxsec_peer_cmp.sv
`timescale 1ns/10ps
`default_nettype none
module rxsec_peer_cmp (
	// Comparison request
	rxsec_cmp_if.cmp c
);
	always_comb
	begin
		c.hit = 1'b0;
		// RULE13: short form compare
		if (c.len == rxsec_pkg::PLEN_SHORT)
		begin
			c.hit = (c.pattern[31:0] == {c.net_id, c.short_id});
		end
		// RULE14: long form compare
		else if (c.len == rxsec_pkg::PLEN_LONG)
		begin
			c.hit = (c.pattern == c.long_id);
		end
	end
endmodule
`default_nettype wire

// File: tb/rxsec_tables.sv
`timescale 1ns/10ps
`default_nettype none
module rxsec_tables (
	// Clock
	input wire logic mclk_i,
	// Key match table
	input wire logic [1:0] km_key_i,
	input wire logic [0:0] km_idx_i,
	output logic km_valid_o,
	output logic [1:0] km_code_o,
	output logic [71:0] km_pattern_o,
	// Link table
	input wire logic [1:0] lk_idx_i,
	output logic lk_valid_o,
	output logic [2:0] lk_peer_idx_o,
	output logic lk_single_o,
	output logic lk_revoked_o,
	// Peer table
	input wire logic [2:0] pe_idx_i,
	output logic [15:0] pe_net_id_o,
	output logic [15:0] pe_short_id_o,
	output logic [63:0] pe_long_id_o
);
	// ----------------------------------------
	// Contents, loaded by the bench
	// ----------------------------------------
	logic [74:0] km [8];
	logic [5:0] lk [16];
	logic [95:0] pe [8];

	// ----------------------------------------
	// Reads answer one cycle after the address
	// ----------------------------------------
	always_ff @(posedge mclk_i)
	begin
		{km_valid_o, km_code_o, km_pattern_o} <= km[{km_key_i, km_idx_i}];
		{lk_valid_o, lk_peer_idx_o, lk_single_o, lk_revoked_o} <=
			lk[{km_key_i, lk_idx_i}];
		{pe_net_id_o, pe_short_id_o, pe_long_id_o} <= pe[pe_idx_i];
	end
endmodule
`default_nettype wire

// File: tb/rxsec_lookup_test.sv
`timescale 1ns/10ps
`default_nettype none
module rxsec_lookup_test;
	// ----------------------------------------
	// Signals and patterns
	// ----------------------------------------
	localparam logic [63:0] SA = 64'h0123_4567_89ab_cdef;
	localparam logic [15:0] SN = 16'h1a2b;
	localparam logic [15:0] DN = 16'h3c4d;
	localparam logic [71:0] K9 = {SA, 8'h00};
	localparam logic [71:0] K5 = 72'h11_2233_4455;
	logic mclk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [3:0] addr_i = 4'h0;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic start_i = 1'b0;
	logic net_comp_i = 1'b0;
	logic [1:0] src_mode_i = 2'h0;
	logic [15:0] src_net_id_i = 16'h0;
	logic [15:0] dst_net_id_i = 16'h0;
	logic [63:0] src_addr_i = 64'h0;
	logic [71:0] key_pattern_i = 72'h0;
	logic [3:0] key_len_i = 4'h0;
	logic [31:0] rdata_o;
	logic [1:0] km_key_o, km_code_i, lk_idx_o;
	logic [0:0] km_idx_o;
	logic [71:0] km_pattern_i;
	logic [2:0] lk_peer_idx_i, pe_idx_o;
	logic [15:0] pe_net_id_i, pe_short_id_i;
	logic [63:0] pe_long_id_i;
	logic km_valid_i, lk_valid_i, lk_single_i, lk_revoked_i;
	logic busy_o, done_o, pass_o;
	int failures = 0;
	int tests_run = 0;

	rxsec_lookup i_rxsec_lookup (
		.mclk_i(mclk_i), .srst_i(srst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.start_i(start_i), .src_mode_i(src_mode_i), .net_comp_i(net_comp_i),
		.src_net_id_i(src_net_id_i), .dst_net_id_i(dst_net_id_i),
		.src_addr_i(src_addr_i), .key_pattern_i(key_pattern_i),
		.key_len_i(key_len_i), .km_key_o(km_key_o), .km_idx_o(km_idx_o),
		.km_valid_i(km_valid_i), .km_code_i(km_code_i),
		.km_pattern_i(km_pattern_i), .lk_idx_o(lk_idx_o),
		.lk_valid_i(lk_valid_i), .lk_peer_idx_i(lk_peer_idx_i),
		.lk_single_i(lk_single_i), .lk_revoked_i(lk_revoked_i),
		.pe_idx_o(pe_idx_o), .pe_net_id_i(pe_net_id_i),
		.pe_short_id_i(pe_short_id_i), .pe_long_id_i(pe_long_id_i),
		.busy_o(busy_o), .done_o(done_o), .pass_o(pass_o));

	rxsec_tables i_rxsec_tables (
		.mclk_i(mclk_i), .km_key_i(km_key_o), .km_idx_i(km_idx_o),
		.km_valid_o(km_valid_i), .km_code_o(km_code_i),
		.km_pattern_o(km_pattern_i), .lk_idx_i(lk_idx_o),
		.lk_valid_o(lk_valid_i), .lk_peer_idx_o(lk_peer_idx_i),
		.lk_single_o(lk_single_i), .lk_revoked_o(lk_revoked_i),
		.pe_idx_i(pe_idx_o), .pe_net_id_o(pe_net_id_i),
		.pe_short_id_o(pe_short_id_i), .pe_long_id_o(pe_long_id_i));

	initial
		forever #4 mclk_i = ~mclk_i;

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	function automatic logic [31:0] res(input logic [7:0] k, l, p);
		return ({24'h0, k} << rxsec_pkg::RES_KEY_POS) |
			({24'h0, l} << rxsec_pkg::RES_LINK_POS) |
			({24'h0, p} << rxsec_pkg::RES_PEER_POS);
	endfunction

	task automatic check(input string nm, input logic [31:0] e, g);
		tests_run++;
		if (g !== e)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic close_out();
		$display("Checks %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic km(input int e, input logic [1:0] c, input logic [71:0] p);
		i_rxsec_tables.km[e] = {1'b1, c, p};
	endtask

	task automatic lk(input int i, input logic [2:0] p, input logic s, r);
		i_rxsec_tables.lk[i] = {1'b1, p, s, r};
	endtask

	task automatic clr();
		for (int i = 0; i < 8; i++)
			i_rxsec_tables.km[i] = '0;
		for (int i = 0; i < 16; i++)
			i_rxsec_tables.lk[i] = '0;
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge mclk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1;
		check("rdata", e, rdata_o);
		@(posedge mclk_i);
		#1;
		check("rdata_idle", 32'h0, rdata_o);
	endtask

	// Starts a search by pin or register, second start mid-run is ignored
	task automatic run(input logic r, input logic [1:0] m, input logic c,
		input logic [3:0] kl, input logic [71:0] kp, input logic ep,
		input logic [31:0] er, input int cy);
		int n;
		// Counted from the edge that launches the start request
		n = 1;
		@(posedge mclk_i);
		src_mode_i <= m;
		net_comp_i <= c;
		src_net_id_i <= SN;
		dst_net_id_i <= DN;
		src_addr_i <= SA;
		key_len_i <= kl;
		key_pattern_i <= kp;
		start_i <= !r;
		wr_i <= r;
		addr_i <= rxsec_pkg::REG_CTRL;
		wdata_i <= 32'h1;
		@(posedge mclk_i);
		start_i <= 1'b0;
		wr_i <= 1'b0;
		src_mode_i <= ~m;
		net_comp_i <= !c;
		src_net_id_i <= DN;
		src_addr_i <= ~SA;
		key_pattern_i <= ~kp;
		#1;
		check("busy", 32'h1, {31'h0, busy_o});
		while (done_o !== 1'b1 && n < 100)
		begin
			@(posedge mclk_i);
			start_i <= (n == 1);
			n++;
			#1;
		end
		check("cycles", cy, n);
		check("pass", {31'h0, ep}, {31'h0, pass_o});
		if (ep)
			check("indices", er, res(km_key_o, lk_idx_o, pe_idx_o));
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		for (int i = 0; i < 8; i++)
			i_rxsec_tables.pe[i] = '0;
		i_rxsec_tables.pe[0] = {SN, SA[15:0], 64'h0};
		i_rxsec_tables.pe[1] = {DN, SA[15:0], 64'h0};
		i_rxsec_tables.pe[2] = {32'h0, SA};
		i_rxsec_tables.pe[3] = {32'h0, SA ^ 64'h1};
		clr();
		repeat (16) @(posedge mclk_i);
		srst_i <= 1'b0;
		#1;
		check("busy_reset", 32'h0, {31'h0, busy_o});
		km(0, 2'h1, K9);
		lk(0, 3'h2, 1'b0, 1'b0);
		run(0, 2'h3, 0, 4'h9, K9, 1, res(0, 0, 2), 7); // Long
		clr();
		km(0, 2'h1, K5);
		km(4, 2'h0, K5 ^ 72'h1);
		km(5, 2'h0, K5);
		lk(8, 3'h0, 1'b0, 1'b0);
		lk(9, 3'h1, 1'b0, 1'b0);
		run(0, 2'h2, 1, 4'h5, K5, 1, res(2, 1, 1), 21); // Short
		lk(8, 3'h1, 1'b0, 1'b0);
		lk(9, 3'h0, 1'b0, 1'b1);
		run(0, 2'h2, 0, 4'h5, K5, 0, 0, 21); // Revoked
		clr();
		km(0, 2'h1, K9);
		lk(0, 3'h4, 1'b1, 1'b0);
		run(1, 2'h0, 0, 4'h9, K9, 1, res(0, 0, 4), 7); // Single
		rd(rxsec_pkg::REG_STATUS, 32'h6); // Status after pass
		rd(rxsec_pkg::REG_RESULT, res(0, 0, 4)); // Result word
		rd(4'hc, 32'h0);
		wr(rxsec_pkg::REG_STATUS, 32'h1);
		rd(rxsec_pkg::REG_STATUS, 32'h6);
		lk(0, 3'h4, 1'b1, 1'b1);
		run(0, 2'h0, 0, 4'h9, K9, 0, 0, 7); // Single revoked
		clr();
		for (int e = 0; e < 8; e++)
			km(e, e[0] ? 2'h3 : 2'h2, K9);
		run(0, 2'h3, 0, 4'h9, K9, 0, 0, 17); // No key
		clr();
		km(0, 2'h1, K9);
		lk(0, 3'h3, 1'b0, 1'b0);
		lk(1, 3'h0, 1'b0, 1'b0);
		lk(2, 3'h1, 1'b0, 1'b0);
		lk(3, 3'h3, 1'b0, 1'b0);
		run(0, 2'h3, 0, 4'h9, K9, 0, 0, 19); // Out of links
		clr();
		km(0, 2'h1, K9);
		lk(0, 3'h5, 1'b0, 1'b0);
		run(0, 2'h0, 0, 4'h9, K9, 0, 0, 9); // No length, list end
		close_out();
	end

	initial
	begin
		repeat (2000) @(posedge mclk_i);
		failures++;
		close_out();
	end
endmodule
`default_nettype wire
